// file: logic/sec_pkg.sv
// Constants, codes and state type shared by the serial EEPROM controller files
`default_nettype none
package sec_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLOCK_MHZ = 100;
	localparam int SK_HALF_NS = 500;
	localparam int SK_HALF_CYCLES = (SK_HALF_NS * CLOCK_MHZ + 999) / 1000;
	localparam int TIMEOUT_MS = 30;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLOCK_MHZ * 1000;

	// ==========================================================
	// Widths and layout
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int CODE_W = 3;
	localparam int FRAME_W = 18;
	localparam int STATION_W = 48;
	localparam logic [4:0] FRAME_LEN_SHORT = 5'h0a;
	localparam logic [4:0] FRAME_LEN_LONG = 5'h12;
	localparam logic [4:0] HEADER_LEN = 5'h0a;
	localparam logic [2:0] STATION_LAST = 3'h6;

	// ==========================================================
	// Signature and reset values
	localparam logic [7:0] SIGNATURE = 8'ha5;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [47:0] STATION_RESET = 48'h0;

	// ==========================================================
	// Host command codes
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_ENABLE = 3'h1;
	localparam logic [2:0] CMD_ERASE = 3'h2;
	localparam logic [2:0] CMD_WRITE = 3'h3;
	localparam logic [2:0] CMD_ERASE_ALL = 3'h4;
	localparam logic [2:0] CMD_WRITE_ALL = 3'h5;
	localparam logic [2:0] CMD_DISABLE = 3'h6;
	localparam logic [2:0] CMD_RELOAD = 3'h7;

	// ==========================================================
	// Serial opcodes and extended-command address prefixes
	localparam logic [1:0] OP_EXT = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [6:0] EXT_DISABLE = 7'h00;
	localparam logic [6:0] EXT_WRITE_ALL = 7'h20;
	localparam logic [6:0] EXT_ERASE_ALL = 7'h40;
	localparam logic [6:0] EXT_ENABLE = 7'h60;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {SEC_IDLE, SEC_FRAME, SEC_GAP, SEC_READY, SEC_FINISH} sec_state_t;
endpackage
`default_nettype wire

// file: logic/sec_sync.sv
// Two-flop synchroniser for the serial data pin input
`timescale 1ns/1ns
`default_nettype none
module sec_sync
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1_reg;
	logic stage2_reg;

	// ==========================================================
	// Two stages, first stage read only by the second
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end
		else
		begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;
endmodule // sec_sync
`default_nettype wire

// file: logic/sec_tick.sv
// Divider giving one-cycle enable pulses at each serial clock half period
`timescale 1ns/1ns
`default_nettype none
module sec_tick
	import sec_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	output logic tick_out
);
	localparam logic [7:0] LAST = 8'(SK_HALF_CYCLES - 1);
	logic [7:0] count_reg;
	logic [7:0] count_next;

	// ==========================================================
	// Count while running, restart from zero when stopped
	always_comb
	begin
		count_next = 8'h00;
		if (run_in && count_reg != LAST)
			count_next = count_reg + 8'h01;
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			count_reg <= 8'h00;
		else
			count_reg <= count_next;
	end

	assign tick_out = run_in && (count_reg == LAST);
endmodule // sec_tick
`default_nettype wire

// file: logic/sec_ctrl.sv
// Serial EEPROM controller: address auto-load and host command sequencer
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RULE1] After reset or soft reset read byte 00h; present only if A5h.
// [RULE2] When present, read next six bytes into station address bytes 0 to 5.
// [RULE3] After all six bytes load, set the address loaded bit.
// [RULE4] Wrong signature ends loading, station address untouched; host writes it.
// [RULE5] Reload command repeats check and load; loaded bit only on success.
// [RULE6] Host starts no command until the automatic load has finished.
// [RULE7] Host loads data register before write commands, then code and address.
// [RULE8] Command starts when busy is set; busy clears when it completes.
// [RULE9] Host reads fetched byte only after busy clears.
// [RULE10] Host leaves the command register alone while busy is set.
// [RULE11] No response within 30 ms abandons the command and sets timeout.
// [RULE12] Erase clears the addressed byte when the memory is write enabled.
// [RULE13] Erase-all clears every byte when the memory is write enabled.
// [RULE14] After disable the memory ignores erase and write commands.
// [RULE15] After enable the memory accepts modification until disable or power off.
// [RULE16] Host issues enable before any erase or write.
// [RULE17] Read fetches the addressed byte into the data register.
// [RULE18] Write stores the data register into the addressed byte.
// [RULE19] Write-all stores the data register into every byte.
// [RULE20] Ten serial clocks for erase, erase-all, enable, disable; eighteen otherwise.
// [RULE21] Interface disabled: data and clock pins become general purpose outputs.
// [RULE22] Memory addressed as 128 bytes by a seven-bit address.
// [RULE23] Frame: start bit, two-bit opcode, seven-bit address, data, MSB first.
// [RULE24] After write or erase frames wait for ready on data line, with timeout.
module sec_ctrl
	import sec_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES_P = sec_pkg::TIMEOUT_CYCLES
)
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic soft_reset_in,
	input wire logic [sec_pkg::CODE_W-1:0] command_code_field_in,
	input wire logic [sec_pkg::ADDR_W-1:0] command_address_field_in,
	input wire logic command_busy_set_in,
	input wire logic data_write_in,
	input wire logic [sec_pkg::DATA_W-1:0] data_in,
	input wire logic station_write_in,
	input wire logic [sec_pkg::STATION_W-1:0] station_in,
	input wire logic interface_enable_in,
	input wire logic gpio_clock_in,
	input wire logic gpio_data_in,
	output logic command_busy_bit_out,
	output logic response_timeout_bit_out,
	output logic address_loaded_bit_out,
	output logic [sec_pkg::DATA_W-1:0] eeprom_data_reg_out,
	output logic [sec_pkg::STATION_W-1:0] station_address_out,
	output logic serial_prom_clock_pin_out,
	output logic serial_prom_select_out,
	output logic serial_prom_data_pin_out,
	output logic serial_prom_data_pin_oe_out,
	input wire logic serial_prom_data_pin_in
);
	import sec_pkg::*;

	// ==========================================================
	// Declarations
	sec_state_t state_reg, state_next;
	logic [FRAME_W-1:0] shift_reg, shift_next;
	logic [4:0] bit_count_reg, bit_count_next;
	logic [4:0] len_reg, len_next;
	logic phase_reg, phase_next;
	logic rx_mode_reg, rx_mode_next;
	logic wait_ready_reg, wait_ready_next;
	logic [31:0] timer_reg, timer_next;
	logic boot_reg, boot_next;
	logic load_active_reg, load_active_next;
	logic [2:0] load_index_reg, load_index_next;
	logic busy_reg, busy_next;
	logic timeout_reg, timeout_next;
	logic loaded_reg, loaded_next;
	logic [DATA_W-1:0] eeprom_data_reg, eeprom_data_next;
	logic [STATION_W-1:0] station_reg, station_next;
	logic pin_clock_reg, pin_clock_next;
	logic pin_select_reg, pin_select_next;
	logic pin_data_reg, pin_data_next;
	logic pin_oe_reg, pin_oe_next;
	logic data_sync;
	logic tick;
	logic tick_run;
	logic [DATA_W-1:0] rx_byte;

	// ==========================================================
	// Data pin synchroniser and serial clock divider
	sec_sync u_sync
	(
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.async_in(serial_prom_data_pin_in),
		.sync_out(data_sync)
	);

	assign tick_run = (state_reg == SEC_FRAME) || (state_reg == SEC_GAP);

	sec_tick u_tick
	(
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.run_in(tick_run),
		.tick_out(tick)
	);

	assign rx_byte = shift_reg[DATA_W-1:0];

	// Build one frame: start bit, opcode, address, then data or input slots
	function automatic void load_frame(input logic [2:0] code, input logic [6:0] addr);
		logic [1:0] op;
		logic [6:0] a;
		logic long_frame;
		op = OP_EXT;
		a = addr; // [RULE22]
		long_frame = 1'b0;
		case (code)
			CMD_READ: begin op = OP_READ; long_frame = 1'b1; end // [RULE17]
			CMD_WRITE: begin op = OP_WRITE; long_frame = 1'b1; end // [RULE18]
			CMD_ERASE: op = OP_ERASE; // [RULE12]
			CMD_ERASE_ALL: a = EXT_ERASE_ALL; // [RULE13]
			CMD_WRITE_ALL: begin a = EXT_WRITE_ALL; long_frame = 1'b1; end // [RULE19]
			CMD_ENABLE: a = EXT_ENABLE;
			CMD_DISABLE: a = EXT_DISABLE;
			default: op = OP_EXT;
		endcase
		shift_next = {1'b1, op, a, eeprom_data_reg}; // [RULE23]
		len_next = long_frame ? FRAME_LEN_LONG : FRAME_LEN_SHORT; // [RULE20]
		rx_mode_next = (code == CMD_READ);
		wait_ready_next = (code == CMD_WRITE) || (code == CMD_ERASE) ||
			(code == CMD_ERASE_ALL) || (code == CMD_WRITE_ALL); // [RULE24]
		bit_count_next = 5'h00;
		phase_next = 1'b0;
		state_next = SEC_FRAME;
	endfunction

	// ==========================================================
	// Sequencer next-state logic
	always_comb
	begin
		state_next = state_reg;
		shift_next = shift_reg;
		bit_count_next = bit_count_reg;
		len_next = len_reg;
		phase_next = phase_reg;
		rx_mode_next = rx_mode_reg;
		wait_ready_next = wait_ready_reg;
		timer_next = timer_reg;
		boot_next = boot_reg;
		load_active_next = load_active_reg;
		load_index_next = load_index_reg;
		busy_next = busy_reg;
		timeout_next = timeout_reg;
		loaded_next = loaded_reg;
		eeprom_data_next = eeprom_data_reg;
		station_next = station_reg;
		// Host writes; hardware results below take precedence
		if (data_write_in)
			eeprom_data_next = data_in;
		if (station_write_in && !load_active_reg)
			station_next = station_in; // [RULE4]
		case (state_reg)
			SEC_IDLE:
			begin
				if (boot_reg || soft_reset_in || (command_busy_set_in &&
					command_code_field_in == CMD_RELOAD))
				begin
					// Auto-load or reload starts with the signature read
					boot_next = 1'b0;
					busy_next = 1'b1;
					timeout_next = 1'b0;
					loaded_next = 1'b0; // [RULE5]
					load_active_next = 1'b1;
					load_index_next = 3'h0;
					load_frame(CMD_READ, 7'h00); // [RULE1]
				end
				else if (command_busy_set_in)
				begin
					busy_next = 1'b1; // [RULE8]
					timeout_next = 1'b0;
					load_frame(command_code_field_in, command_address_field_in);
				end
			end
			SEC_FRAME:
			begin
				if (tick && !phase_reg)
				begin
					// Rising serial clock: shift out next bit, capture input
					phase_next = 1'b1;
					shift_next = {shift_reg[FRAME_W-2:0], data_sync}; // [RULE23]
					bit_count_next = bit_count_reg + 5'h01;
				end
				else if (tick)
				begin
					phase_next = 1'b0;
					if (bit_count_reg == len_reg)
						state_next = SEC_GAP; // [RULE20]
				end
			end
			SEC_GAP:
			begin
				// Select low for one half period between frames
				if (tick)
				begin
					timer_next = 32'h0;
					state_next = wait_ready_reg ? SEC_READY : SEC_FINISH;
				end
			end
			SEC_READY:
			begin
				if (data_sync && timer_reg >= 32'(SK_HALF_CYCLES)) // Line settles first
					state_next = SEC_FINISH; // [RULE24]
				else if (timer_reg == TIMEOUT_CYCLES_P - 32'h1)
				begin
					timeout_next = 1'b1; // [RULE11]
					state_next = SEC_FINISH;
				end
				else
					timer_next = timer_reg + 32'h1;
			end
			SEC_FINISH:
			begin
				state_next = SEC_IDLE;
				busy_next = 1'b0; // [RULE8]
				if (load_active_reg)
				begin
					if (load_index_reg == 3'h0 && rx_byte != SIGNATURE)
						load_active_next = 1'b0; // [RULE4]
					else
					begin
						if (load_index_reg != 3'h0)
							station_next[{load_index_reg - 3'h1, 3'h0} +: 8] = rx_byte; // [RULE2]
						if (load_index_reg == STATION_LAST)
						begin
							load_active_next = 1'b0;
							loaded_next = 1'b1; // [RULE3]
						end
						else
						begin
							busy_next = 1'b1;
							load_index_next = load_index_reg + 3'h1;
							load_frame(CMD_READ, {4'h0, load_index_reg + 3'h1}); // [RULE2]
						end
					end
				end
				else if (rx_mode_reg)
					eeprom_data_next = rx_byte; // [RULE17]
			end
			default: state_next = SEC_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= SEC_IDLE;
			shift_reg <= '0;
			bit_count_reg <= 5'h00;
			len_reg <= FRAME_LEN_SHORT;
			phase_reg <= 1'b0;
			rx_mode_reg <= 1'b0;
			wait_ready_reg <= 1'b0;
			timer_reg <= 32'h0;
			boot_reg <= 1'b1;
			load_active_reg <= 1'b0;
			load_index_reg <= 3'h0;
			busy_reg <= 1'b0;
			timeout_reg <= 1'b0;
			loaded_reg <= 1'b0;
			eeprom_data_reg <= DATA_RESET;
			station_reg <= STATION_RESET;
		end
		else
		begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bit_count_reg <= bit_count_next;
			len_reg <= len_next;
			phase_reg <= phase_next;
			rx_mode_reg <= rx_mode_next;
			wait_ready_reg <= wait_ready_next;
			timer_reg <= timer_next;
			boot_reg <= boot_next;
			load_active_reg <= load_active_next;
			load_index_reg <= load_index_next;
			busy_reg <= busy_next;
			timeout_reg <= timeout_next;
			loaded_reg <= loaded_next;
			eeprom_data_reg <= eeprom_data_next;
			station_reg <= station_next;
		end
	end

	// ==========================================================
	// Pin drivers, switched to general purpose use when disabled
	always_comb
	begin
		pin_clock_next = gpio_clock_in; // [RULE21]
		pin_data_next = gpio_data_in; // [RULE21]
		pin_oe_next = 1'b1;
		pin_select_next = 1'b0;
		if (interface_enable_in)
		begin
			pin_clock_next = phase_reg && (state_reg == SEC_FRAME);
			pin_select_next = (state_reg == SEC_FRAME) || (state_reg == SEC_READY);
			pin_data_next = phase_reg ? pin_data_reg : shift_reg[FRAME_W-1]; // [RULE23]
			// Data and read release move only on falling clocks, never under a rise
			pin_oe_next = (state_reg == SEC_FRAME) && !(rx_mode_reg &&
				(bit_count_reg > HEADER_LEN || (bit_count_reg == HEADER_LEN && !phase_reg)));
		end
	end

	// Pin registers
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pin_clock_reg <= 1'b0;
			pin_select_reg <= 1'b0;
			pin_data_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
		end
		else
		begin
			pin_clock_reg <= pin_clock_next;
			pin_select_reg <= pin_select_next;
			pin_data_reg <= pin_data_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	// ==========================================================
	// Outputs
	assign command_busy_bit_out = busy_reg;
	assign response_timeout_bit_out = timeout_reg;
	assign address_loaded_bit_out = loaded_reg;
	assign eeprom_data_reg_out = eeprom_data_reg;
	assign station_address_out = station_reg;
	assign serial_prom_clock_pin_out = pin_clock_reg;
	assign serial_prom_select_out = pin_select_reg;
	assign serial_prom_data_pin_out = pin_data_reg;
	assign serial_prom_data_pin_oe_out = pin_oe_reg;
endmodule // sec_ctrl
`default_nettype wire

// file: test/sec_ctrl_sva.sv
// Port-level assertion checker for the serial EEPROM controller
`timescale 1ns/1ns
`default_nettype none
module sec_ctrl_sva
	import sec_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES_P = TIMEOUT_CYCLES
)
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic soft_reset_in,
	input wire logic [CODE_W-1:0] command_code_field_in,
	input wire logic command_busy_set_in,
	input wire logic data_write_in,
	input wire logic station_write_in,
	input wire logic interface_enable_in,
	input wire logic gpio_clock_in,
	input wire logic gpio_data_in,
	input wire logic command_busy_bit_out,
	input wire logic response_timeout_bit_out,
	input wire logic [DATA_W-1:0] eeprom_data_reg_out,
	input wire logic [STATION_W-1:0] station_address_out,
	input wire logic serial_prom_clock_pin_out,
	input wire logic serial_prom_select_out,
	input wire logic serial_prom_data_pin_out,
	input wire logic serial_prom_data_pin_oe_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// ==========================================
	// Frame length tracking
	logic [4:0] rise_reg, rise_next;
	logic clk_reg, long_reg, long_next, idle, rise;
	assign idle = !command_busy_bit_out;
	assign rise = serial_prom_clock_pin_out && !clk_reg;
	// Count clock rises per select window and note the frame length owed
	always_comb
	begin
		rise_next = serial_prom_select_out ? rise_reg + 5'(rise) : 5'h00;
		long_next = long_reg;
		if (idle && soft_reset_in)
			long_next = 1'b1;
		else if (idle && command_busy_set_in)
			long_next = command_code_field_in inside {CMD_READ, CMD_WRITE, CMD_WRITE_ALL, CMD_RELOAD};
	end
	// Helper registers
	always_ff @(posedge clock_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			rise_reg <= 5'h00;
			clk_reg <= 1'b0;
			long_reg <= 1'b1;
		end
		else
		begin
			rise_reg <= rise_next;
			clk_reg <= serial_prom_clock_pin_out;
			long_reg <= long_next;
		end
	// ==========================================
	// Assertions
	a_busy_on_set: assert property (idle && command_busy_set_in |=> command_busy_bit_out)
		else $error("busy not raised");
	a_select_in_busy: assert property (serial_prom_select_out |-> command_busy_bit_out)
		else $error("frame outside busy");
	a_timeout_in_op: assert property ($rose(response_timeout_bit_out) |->
		$past(command_busy_bit_out) ##[0:4] idle) else $error("stray timeout");
	a_data_hold: assert property (!$past(command_busy_bit_out) && !$past(data_write_in) |->
		$stable(eeprom_data_reg_out)) else $error("data register moved");
	a_station_hold: assert property (!$past(command_busy_bit_out) && !$past(station_write_in) |->
		$stable(station_address_out)) else $error("station moved");
	a_frame_len: assert property ($fell(serial_prom_select_out) |-> rise_reg == 5'h00 ||
		rise_reg == (long_reg ? FRAME_LEN_LONG : FRAME_LEN_SHORT)) else $error("bad clock count");
	a_gpio_pins: assert property ((!interface_enable_in && $stable({gpio_clock_in, gpio_data_in}))[*3]
		|-> serial_prom_clock_pin_out == gpio_clock_in && serial_prom_data_pin_out == gpio_data_in
		&& serial_prom_data_pin_oe_out && !serial_prom_select_out) else $error("pins not general");
	a_start_bit: assert property ($rose(serial_prom_select_out) && serial_prom_data_pin_oe_out |->
		serial_prom_data_pin_out) else $error("no start bit");
	a_data_at_rise: assert property ($rose(serial_prom_clock_pin_out) &&
		serial_prom_select_out |-> $stable({serial_prom_data_pin_out, serial_prom_data_pin_oe_out}))
		else $error("data moved at clock rise");
	// Main scenarios reached
	c_done: cover property ($fell(command_busy_bit_out));
	c_timeout: cover property ($rose(response_timeout_bit_out));
	c_short: cover property ($fell(serial_prom_select_out) && rise_reg == FRAME_LEN_SHORT);
endmodule // sec_ctrl_sva
`default_nettype wire

// file: test/sec_prom_model.sv
// Behavioural model of the three-wire serial EEPROM on the far side
`timescale 1ns/1ns
`default_nettype none
module sec_prom_model
	import sec_pkg::*;
#(
	parameter logic [7:0] ERASED = 8'hff
)
(
	input wire logic sck_in,
	input wire logic sel_in,
	input wire logic di_in,
	input wire logic stall_in,
	output logic dq_out
);
	logic [7:0] mem [0:127];
	logic [17:0] sh = 18'h00000;
	logic [7:0] rd = 8'h00;
	logic rdg = 1'b0;
	logic wen = 1'b0;
	int cnt = 0;
	time done_t = 0;
	initial dq_out = 1'b0;
	// New select window: restart the bit count
	always @(posedge sel_in)
	begin
		cnt = 0;
		rdg = 1'b0;
	end
	// Shift bits in on clock rises; after the header, read data goes out MSB first
	always @(posedge sck_in)
		if (sel_in)
		begin
			sh = {sh[16:0], di_in};
			cnt = cnt + 1;
			rd = {rd[6:0], 1'b0};
			if (cnt == 10)
			begin
				rdg = sh[9:7] == {1'b1, OP_READ};
				rd = mem[sh[6:0]];
			end
			if (rdg)
				dq_out = rd[7];
		end
	// End of frame: modify commands take effect only while enabled
	always @(negedge sel_in)
	begin
		if (cnt == 10 && sh[9:7] == {1'b1, OP_EXT})
			case (sh[6:5])
				2'h3: wen = 1'b1;
				2'h0: wen = 1'b0;
				2'h2: if (wen) mem = '{default: ERASED};
				default: ;
			endcase
		else if (cnt == 10 && sh[9:7] == {1'b1, OP_ERASE} && wen)
			mem[sh[6:0]] = ERASED;
		else if (cnt == 18 && sh[17:15] == {1'b1, OP_WRITE} && wen)
			mem[sh[14:8]] = sh[7:0];
		else if (cnt == 18 && sh[17:13] == {1'b1, OP_EXT, 2'h1} && wen)
			mem = '{default: sh[7:0]};
		done_t = $time + 1000;
	end
	// Ready status while selected between frames; a toggling pattern once released
	always #50
		if (!sel_in)
			dq_out = ~dq_out;
		else if (cnt == 0)
			dq_out = !stall_in && $time >= done_t;
endmodule // sec_prom_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking testbench for the serial EEPROM controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import sec_pkg::*;
	localparam logic [7:0] ERASED_VAL = 8'hff;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic soft_rst = 1'b0;
	logic [2:0] code = 3'h0;
	logic [6:0] addr = 7'h00;
	logic bset = 1'b0;
	logic dwr = 1'b0;
	logic [7:0] din = 8'h00;
	logic swr = 1'b0;
	logic [47:0] sin = 48'h0;
	logic en = 1'b1;
	logic gck = 1'b0;
	logic gdi = 1'b0;
	logic stall = 1'b0;
	logic busy, tmo, loaded, sck, sel, dout, oe, pdq, pin, wen;
	logic [7:0] dreg;
	logic [47:0] st;
	logic [7:0] ref_mem [0:127];
	logic [9:0] seq [0:14] = '{{CMD_WRITE, 7'h7f}, {CMD_READ, 7'h7f}, {CMD_ENABLE, 7'h00},
		{CMD_WRITE, 7'h7f}, {CMD_READ, 7'h7f}, {CMD_ERASE, 7'h7f}, {CMD_READ, 7'h7f},
		{CMD_DISABLE, 7'h00}, {CMD_ERASE, 7'h00}, {CMD_READ, 7'h00}, {CMD_ENABLE, 7'h00},
		{CMD_WRITE_ALL, 7'h00}, {CMD_READ, 7'h40}, {CMD_ERASE_ALL, 7'h00}, {CMD_READ, 7'h01}};
	int error_cnt = 0;
	int n_checks = 0;
	int seed = 10099;
	// Shared data wire
	assign pin = oe ? dout : pdq;
	always #5 clock_in = ~clock_in;
	sec_ctrl #(.TIMEOUT_CYCLES_P(200)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.soft_reset_in(soft_rst), .command_code_field_in(code), .command_address_field_in(addr),
		.command_busy_set_in(bset), .data_write_in(dwr), .data_in(din), .station_write_in(swr),
		.station_in(sin), .interface_enable_in(en), .gpio_clock_in(gck), .gpio_data_in(gdi),
		.command_busy_bit_out(busy), .response_timeout_bit_out(tmo),
		.address_loaded_bit_out(loaded), .eeprom_data_reg_out(dreg), .station_address_out(st),
		.serial_prom_clock_pin_out(sck), .serial_prom_select_out(sel),
		.serial_prom_data_pin_out(dout), .serial_prom_data_pin_oe_out(oe),
		.serial_prom_data_pin_in(pin));
	sec_prom_model #(.ERASED(ERASED_VAL)) pm (.sck_in(sck), .sel_in(sel), .di_in(pin),
		.stall_in(stall), .dq_out(pdq));
	// ==========================================
	// Tasks
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Wait for busy to clear under a bound
	task automatic wait_idle;
		int n;
		n = 0;
		do
		begin
			@(posedge clock_in);
			#1 n++;
		end
		while (busy !== 1'b0 && n < 20000);
		if (n >= 20000)
		begin
			error_cnt++;
			finish_test();
		end
	endtask
	function automatic logic [47:0] exp_st();
		return {ref_mem[6], ref_mem[5], ref_mem[4], ref_mem[3], ref_mem[2], ref_mem[1]};
	endfunction
	// Reference memory update for one command
	function automatic void upd(input logic [2:0] c, input logic [6:0] a, input logic [7:0] d);
		case (c)
			CMD_ENABLE: wen = 1'b1;
			CMD_DISABLE: wen = 1'b0;
			CMD_ERASE: if (wen) ref_mem[a] = ERASED_VAL;
			CMD_WRITE: if (wen) ref_mem[a] = d;
			CMD_ERASE_ALL: if (wen) ref_mem = '{default: ERASED_VAL};
			CMD_WRITE_ALL: if (wen) ref_mem = '{default: d};
			default: ;
		endcase
	endfunction
	// Load data, issue one command, wait, and check the results
	task automatic op(input logic [2:0] c, input logic [6:0] a);
		logic [7:0] d;
		d = 8'($random(seed));
		din = d;
		dwr = 1'b1;
		@(posedge clock_in);
		#1 dwr = 1'b0;
		code = c;
		addr = a;
		bset = 1'b1;
		@(posedge clock_in);
		#1 bset = 1'b0;
		wait_idle();
		upd(c, a, d);
		check(tmo, stall && c inside {CMD_ERASE, CMD_WRITE, CMD_ERASE_ALL, CMD_WRITE_ALL});
		if (c != CMD_RELOAD)
			check(dreg, c == CMD_READ ? ref_mem[a] : d);
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		wen = 1'b0;
		foreach (ref_mem[i])
			ref_mem[i] = 8'($random(seed));
		ref_mem[0] = SIGNATURE;
		pm.mem = ref_mem;
		repeat (12) @(posedge clock_in);
		#1 rst_n_in = 1'b1;
		wait_idle();
		check(loaded, 1'b1);
		check(st, exp_st());
		repeat (3) op(CMD_READ, 7'($random(seed)));
		foreach (seq[i])
			op(seq[i][9:7], seq[i][6:0]);
		stall = 1'b1;
		op(CMD_WRITE, 7'h05);
		stall = 1'b0;
		op(CMD_READ, 7'h05);
		sin = 48'({$random(seed), $random(seed)});
		swr = 1'b1;
		@(posedge clock_in);
		#1 swr = 1'b0;
		soft_rst = 1'b1;
		@(posedge clock_in);
		#1 soft_rst = 1'b0;
		wait_idle();
		check(loaded, 1'b0);
		check(st, sin);
		for (int k = 0; k < 2; k++)
		begin
			for (int i = 1; i < 7; i++)
				ref_mem[i] = 8'($random(seed));
			ref_mem[0] = k ? SIGNATURE : ~SIGNATURE;
			pm.mem = ref_mem;
			op(CMD_RELOAD, 7'h00);
			check(loaded, k[0]);
			check(st, k ? exp_st() : sin);
		end
		en = 1'b0;
		repeat (4)
		begin
			{gck, gdi} = 2'($random(seed));
			repeat (4) @(posedge clock_in);
			#1 check({sck, dout, oe, sel}, {gck, gdi, 2'b10});
		end
		en = 1'b1;
		finish_test();
	end
	// Watchdog: the sequence needs well under 100,000 clock cycles
	initial
	begin
		#1000000;
		error_cnt++;
		finish_test();
	end
endmodule // testbench
bind sec_ctrl sec_ctrl_sva #(.TIMEOUT_CYCLES_P(TIMEOUT_CYCLES_P)) u_sva (.*);
`default_nettype wire
